// file: inc/quant_sat_pkg.sv
// constants, encodings and carrier types for the fixed-point quantize/saturate datapath
// assumes a single 25 MHz clock domain and a plain address/strobe register port
package quant_sat_pkg;

    // datapath geometry: 16-bit source, 4 low bits discarded, 8-bit target
    localparam int IN_W = 16;
    localparam int DROP_W = 4;
    localparam int OUT_W = 8;
    localparam int KEEP_W = IN_W - DROP_W;
    // two guard bits so a rounding carry on an unsigned maximum stays positive
    localparam int SUM_W = KEEP_W + 2;
    localparam int CNT_W = 16;

    // register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] RESULT_OFS = 4'h8;
    localparam logic [ADDR_W-1:0] COUNT_OFS = 4'hC;

    // control field positions
    localparam int QMODE_LSB = 0;
    localparam int OMODE_LSB = 2;
    localparam int SIGNED_BIT = 5;
    localparam int NBITS_LSB = 8;
    localparam int NBITS_W = 4;

    // status field positions
    localparam int POS_OVF_BIT = 0;
    localparam int NEG_OVF_BIT = 1;
    localparam int INEXACT_BIT = 2;

    // result field positions
    localparam int RES_VALID_BIT = 8;
    localparam int RES_POS_BIT = 9;
    localparam int RES_NEG_BIT = 10;

    // count register halves
    localparam int CONV_CNT_LSB = 0;
    localparam int OVF_CNT_LSB = 16;

    typedef enum logic [1:0] {
        truncate_mode = 2'b00,
        nearest_round_mode = 2'b01,
        convergent_round_mode = 2'b10,
        truncate_toward_zero_mode = 2'b11
    } quant_mode_t;

    typedef enum logic [2:0] {
        saturate_mode = 3'b000,
        saturate_to_zero_mode = 3'b001,
        symmetric_saturate_mode = 3'b010,
        wraparound_mode = 3'b011,
        sign_magnitude_wrap_mode = 3'b100
    } ovf_mode_t;

    typedef struct packed {
        logic [NBITS_W-1:0] n_bits;
        logic is_signed;
        logic [2:0] omode;
        quant_mode_t qmode;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '{n_bits: 4'h0, is_signed: 1'b1, omode: 3'h0, qmode: truncate_mode};

    typedef struct packed {
        logic ovf_pos;
        logic ovf_neg;
        logic inexact;
        logic [OUT_W-1:0] data;
    } conv_result_t;

endpackage : quant_sat_pkg

// file: design/quant_sat.sv
// fixed-point quantize and saturate stage with its control/status register port
// assumes the upstream datapath presents in_data with in_valid synchronous to mclk
`timescale 1ns/10ps
`default_nettype none
module quant_sat
    import quant_sat_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // upstream datapath
    input wire logic in_valid,
    input wire logic [IN_W-1:0] in_data,
    // next stage
    output logic out_valid,
    output logic [OUT_W-1:0] out_data,
    output logic out_ovf,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata
);

    ////////////////////////////////////////////////////////////////////////////
    // limit and conversion arithmetic

    function automatic logic signed [SUM_W-1:0] limit_hi(input logic is_signed, input int width);
        // width 3 signed gives 3, width 3 unsigned gives 7
        limit_hi = is_signed ? SUM_W'((1 << (width - 1)) - 1) : SUM_W'((1 << width) - 1);
    endfunction : limit_hi

    function automatic logic signed [SUM_W-1:0] limit_lo(input logic is_signed, input int width);
        // width 3 signed gives -4, unsigned floors at zero
        limit_lo = is_signed ? SUM_W'(-(1 << (width - 1))) : SUM_W'(0);
    endfunction : limit_lo

    function automatic conv_result_t convert(input logic [IN_W-1:0] din, input ctrl_t c);
        logic [KEEP_W-1:0] kept;
        logic [DROP_W-1:0] dropped;
        logic half;
        logic below_half;
        logic neg;
        logic inc;
        logic signed [SUM_W-1:0] q;
        logic signed [SUM_W-1:0] hi;
        logic signed [SUM_W-1:0] lo;
        conv_result_t r;
        kept = din[IN_W-1:DROP_W];
        dropped = din[DROP_W-1:0];
        half = dropped[DROP_W-1];
        below_half = |dropped[DROP_W-2:0];
        // unsigned formats have no negative values at all
        neg = c.is_signed & din[IN_W-1];
        unique case (c.qmode)
            nearest_round_mode:
            begin
                inc = half;
            end
            convergent_round_mode:
            begin
                // off midway the remainder bits decide, on midway the kept LSB
                inc = half & (below_half | kept[0]);
            end
            truncate_toward_zero_mode:
            begin
                inc = neg & (|dropped);
            end
            truncate_mode:
            begin
                inc = 1'b0;
            end
        endcase
        if (c.is_signed)
        begin
            q = {{(SUM_W-KEEP_W){kept[KEEP_W-1]}}, kept};
        end
        else
        begin
            q = {{(SUM_W-KEEP_W){1'b0}}, kept};
        end
        // carry is added before the range check
        q = q + $signed({{(SUM_W-1){1'b0}}, inc});
        hi = limit_hi(c.is_signed, OUT_W);
        lo = limit_lo(c.is_signed, OUT_W);
        r.ovf_pos = (q > hi);
        r.ovf_neg = (q < lo);
        r.inexact = |dropped;
        // other overflow codes are not defined here and fall back to saturation
        if (r.ovf_pos)
        begin
            r.data = hi[OUT_W-1:0];
        end
        else if (r.ovf_neg)
        begin
            r.data = lo[OUT_W-1:0];
        end
        else
        begin
            r.data = q[OUT_W-1:0];
        end
        return r;
    endfunction : convert

    ////////////////////////////////////////////////////////////////////////////
    // control register

    ctrl_t ctrl;
    conv_result_t conv;
    logic write_ctrl;
    logic write_status;
    logic write_count;
    logic ovf_event;

    // one strobe-and-offset match, shared by every writable register
    function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
        hit = strobe && (addr == ofs);
    endfunction : hit

    assign write_ctrl = hit(reg_write, reg_addr, CTRL_OFS);
    assign write_status = hit(reg_write, reg_addr, STATUS_OFS);
    assign write_count = hit(reg_write, reg_addr, COUNT_OFS);

    // overflow code and n_bits are kept for software only; every code saturates
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl <= CTRL_RESET;
        end
        else if (write_ctrl)
        begin
            ctrl.qmode <= quant_mode_t'(reg_wdata[QMODE_LSB +: 2]);
            ctrl.omode <= reg_wdata[OMODE_LSB +: 3];
            ctrl.is_signed <= reg_wdata[SIGNED_BIT];
            ctrl.n_bits <= reg_wdata[NBITS_LSB +: NBITS_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // conversion pipeline stage

    assign conv = convert(in_data, ctrl);
    assign ovf_event = in_valid && (conv.ovf_pos || conv.ovf_neg);

    conv_result_t last;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_valid <= 1'b0;
        end
        else
        begin
            out_valid <= in_valid;
        end
    end

    // data and flag hold their last word while the input idles
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_data <= '0;
        end
        else if (in_valid)
        begin
            out_data <= conv.data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_ovf <= 1'b0;
        end
        else if (in_valid)
        begin
            out_ovf <= conv.ovf_pos | conv.ovf_neg;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last <= '0;
        end
        else if (in_valid)
        begin
            last <= conv;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky status, write one to clear; a new event in the clearing cycle stays set

    logic [2:0] sticky;
    logic [2:0] sticky_set;
    logic [2:0] sticky_clr;

    assign sticky_set[POS_OVF_BIT] = in_valid & conv.ovf_pos;
    assign sticky_set[NEG_OVF_BIT] = in_valid & conv.ovf_neg;
    assign sticky_set[INEXACT_BIT] = in_valid & conv.inexact;
    assign sticky_clr = {3{write_status}} & reg_wdata[2:0];

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sticky <= '0;
        end
        else
        begin
            sticky <= (sticky & ~sticky_clr) | sticky_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event counters, any write to the count register clears both

    logic [CNT_W-1:0] conv_cnt;
    logic [CNT_W-1:0] ovf_cnt;

    // a clear keeps an event landing in the clearing cycle; counts wrap,
    // software reads and clears well before that
    function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] cnt, input logic clear, input logic seen);
        logic [CNT_W-1:0] next_cnt;
        next_cnt = cnt;
        if (clear)
        begin
            next_cnt = {{(CNT_W-1){1'b0}}, seen};
        end
        else if (seen)
        begin
            next_cnt = cnt + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        return next_cnt;
    endfunction : bump

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            conv_cnt <= '0;
        end
        else
        begin
            conv_cnt <= bump(conv_cnt, write_count, in_valid);
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ovf_cnt <= '0;
        end
        else
        begin
            ovf_cnt <= bump(ovf_cnt, write_count, ovf_event);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port, data stands only in the cycle after the strobe

    logic [DATA_W-1:0] next_rdata;

    always_comb
    begin
        next_rdata = '0;
        unique case (reg_addr)
            CTRL_OFS:
            begin
                next_rdata[QMODE_LSB +: 2] = ctrl.qmode;
                next_rdata[OMODE_LSB +: 3] = ctrl.omode;
                next_rdata[SIGNED_BIT] = ctrl.is_signed;
                next_rdata[NBITS_LSB +: NBITS_W] = ctrl.n_bits;
            end
            STATUS_OFS:
            begin
                next_rdata[2:0] = sticky;
            end
            RESULT_OFS:
            begin
                next_rdata[OUT_W-1:0] = last.data;
                next_rdata[RES_VALID_BIT] = out_valid;
                next_rdata[RES_POS_BIT] = last.ovf_pos;
                next_rdata[RES_NEG_BIT] = last.ovf_neg;
            end
            COUNT_OFS:
            begin
                next_rdata[CONV_CNT_LSB +: CNT_W] = conv_cnt;
                next_rdata[OVF_CNT_LSB +: CNT_W] = ovf_cnt;
            end
            default:
            begin
                next_rdata = '0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= '0;
        end
        else if (reg_read)
        begin
            reg_rdata <= next_rdata;
        end
        else
        begin
            // zero between answers, so several slaves may share one OR-ed return path
            reg_rdata <= '0;
        end
    end

endmodule : quant_sat
`default_nettype wire

// file: sim/upstream_model.sv
// upstream datapath model: hands fixed-point samples to the quantizer
// assumes the bench owns mclk; drives only right after rising edges
`timescale 1ns/10ps
`default_nettype none
module upstream_model
    import quant_sat_pkg::*;
(
    // clock
    input wire logic mclk,
    // sample output
    output logic in_valid,
    output logic [IN_W-1:0] in_data
);
    initial
    begin
        in_valid = 1'b0;
        in_data = '0;
    end
    // n back-to-back copies; idle data is inverted so a stale word is never mistaken
    task automatic send(input logic [IN_W-1:0] d, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge mclk);
            in_valid <= 1'b1;
            in_data <= d;
        end
        @(posedge mclk);
        in_valid <= 1'b0;
        in_data <= ~d;
    endtask : send
endmodule : upstream_model
`default_nettype wire

// file: sim/quant_sat_checker.sv
// port-level checks of the quantize/saturate stage
// assumes one mclk domain and bind onto every quant_sat instance
`timescale 1ns/10ps
`default_nettype none
module quant_sat_checker
    import quant_sat_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // datapath
    input wire logic in_valid,
    input wire logic [IN_W-1:0] in_data,
    input wire logic out_valid,
    input wire logic [OUT_W-1:0] out_data,
    input wire logic out_ovf,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [DATA_W-1:0] reg_rdata
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // sample that produced the word now on out_data
    logic [IN_W-1:0] prev_in;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            prev_in <= '0;
        else if (in_valid)
            prev_in <= in_data;
    end
    ////////////////////////////////////////////////////////////
    sequence burst_s;
        in_valid ##1 in_valid;
    endsequence
    sequence answer_s;
        out_valid ##1 out_valid;
    endsequence
    valid_lat_a: assert property (in_valid |=> out_valid)
        else $error("no output one cycle after input");
    no_spur_a: assert property (!in_valid |=> !out_valid)
        else $error("output valid without input");
    hold_out_a: assert property (!in_valid |=> $stable(out_data) && $stable(out_ovf))
        else $error("output changed without input");
    burst_out_a: assert property (burst_s |-> answer_s)
        else $error("back-to-back samples lost");
    ovf_big_a: assert property (in_valid && in_data[15] != in_data[14] |=> out_ovf)
        else $error("large input not flagged");
    limit_only_a: assert property (out_valid && out_ovf |-> out_data inside {8'h7F, 8'h80, 8'hFF})
        else $error("overflow output is not a limit");
    small_in_a: assert property (out_valid && prev_in[15:10] == 6'h00 |->
        !out_ovf && (out_data - prev_in[11:4]) <= 8'h01)
        else $error("small input moved by more than one step");
    exact_in_a: assert property (out_valid && prev_in[3:0] == 4'h0 && prev_in[15:10] == 6'h00 |->
        out_data == prev_in[11:4])
        else $error("exact input altered");
    rdata_idle_a: assert property (!reg_read |=> reg_rdata == '0)
        else $error("read data outside the answer cycle");
endmodule : quant_sat_checker
bind quant_sat quant_sat_checker chk (.mclk, .rst_n, .in_valid, .in_data, .out_valid, .out_data,
    .out_ovf, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
`default_nettype wire

// file: sim/quant_sat_tb.sv
// self-checking bench for the quantize/saturate stage
// assumes upstream_model and the bound checker are compiled alongside
`timescale 1ns/10ps
`default_nettype none
module quant_sat_tb
    import quant_sat_pkg::*;
;
    logic mclk, rst_n, in_valid, out_valid, out_ovf, reg_write, reg_read;
    logic [IN_W-1:0] in_data;
    logic [OUT_W-1:0] out_data;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    int miscompares;
    int compares;
    quant_sat dut (.mclk, .rst_n, .in_valid, .in_data, .out_valid, .out_data, .out_ovf,
        .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
    upstream_model up (.mclk, .in_valid, .in_data);
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge mclk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1;
        check("reg_rdata", exp, reg_rdata);
    endtask : rd
    // floor of kept bits plus the mode's increment, then clamp; carry is added before the clamp
    function automatic logic [8:0] expect_conv(input logic [15:0] x, input logic [1:0] q, input logic s);
        int k;
        k = s ? int'($signed(x[15:4])) : int'(x[15:4]);
        case (q)
            2'h1: k += x[3];
            2'h2: k += x[3] & ((|x[2:0]) | x[4]);
            2'h3: k += s & x[15] & (|x[3:0]);
            default: ;
        endcase
        if (k > (s ? 127 : 255))
            return {1'b1, s ? 8'h7F : 8'hFF};
        if (k < (s ? -128 : 0))
            return {1'b1, 8'h80};
        return {1'b0, k[7:0]};
    endfunction : expect_conv
    task automatic conv(input logic [15:0] x, input logic [1:0] q, input logic s, input int n);
        logic [8:0] e;
        e = expect_conv(x, q, s);
        up.send(x, n);
        #1;
        check("out_data", 32'(e[7:0]), 32'(out_data));
        check("out_ovf", 32'(e[8]), 32'(out_ovf));
        check("out_valid", 32'h1, 32'(out_valid));
    endtask : conv
    ////////////////////////////////////////////////////////////
    task automatic t_reset_state();
        rd(CTRL_OFS, 32'h20);
        rd(STATUS_OFS, 32'h0);
        rd(RESULT_OFS, 32'h0);
        rd(COUNT_OFS, 32'h0);
        rd(4'h2, 32'h0);
        conv(16'hFEC4, 2'h0, 1'b1, 1);
    endtask : t_reset_state
    task automatic t_modes();
        logic [15:0] vec [10] = '{16'h0128, 16'h0138, 16'h012C, 16'h0124, 16'h0120,
            16'hFED8, 16'hFEC4, 16'h7FF8, 16'h8000, 16'h0FF8};
        for (int q = 0; q < 4; q++)
            for (int s = 0; s < 2; s++)
                for (int i = 0; i < 10; i++)
                begin
                    // every overflow code is exercised; all of them saturate here
                    wr(CTRL_OFS, 32'((s << SIGNED_BIT) | ((i % 5) << OMODE_LSB) | q));
                    conv(vec[i], 2'(q), 1'(s), 1);
                end
    endtask : t_modes
    task automatic t_sticky_counts();
        wr(STATUS_OFS, 32'h7);
        wr(COUNT_OFS, 32'h0);
        rd(COUNT_OFS, 32'h0);
        wr(CTRL_OFS, 32'hF21);
        conv(16'h7FF8, 2'h1, 1'b1, 3);
        rd(STATUS_OFS, 32'h5);
        rd(COUNT_OFS, 32'h0003_0003);
        rd(RESULT_OFS, 32'h27F);
        wr(STATUS_OFS, 32'h1);
        rd(STATUS_OFS, 32'h4);
        wr(4'h2, 32'hFFFF_FFFF);
        rd(CTRL_OFS, 32'hF21);
    endtask : t_sticky_counts
    // a clear and a new event in one cycle: the event survives in flag and counter
    task automatic t_set_wins();
        wr(CTRL_OFS, 32'h21);
        fork
            wr(STATUS_OFS, 32'h7);
            up.send(16'h7FF8, 1);
        join
        rd(STATUS_OFS, 32'h5);
        fork
            wr(COUNT_OFS, 32'h0);
            up.send(16'h7FF8, 1);
        join
        rd(COUNT_OFS, 32'h0001_0001);
    endtask : t_set_wins
    task automatic t_midrun_reset();
        up.send(16'h4000, 1);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        check("out_data", 32'h0, 32'(out_data));
        check("out_ovf", 32'h0, 32'(out_ovf));
        check("out_valid", 32'h0, 32'(out_valid));
        @(posedge mclk);
        rst_n <= 1'b1;
        rd(CTRL_OFS, 32'h20);
        rd(STATUS_OFS, 32'h0);
        rd(COUNT_OFS, 32'h0);
        conv(16'hFED8, 2'h0, 1'b1, 1);
    endtask : t_midrun_reset
    task automatic tally_and_finish();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        rst_n = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        miscompares = 0;
        compares = 0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset_state();
        t_modes();
        t_sticky_counts();
        t_set_wins();
        t_midrun_reset();
        tally_and_finish();
    end
    // the whole run needs about 400 cycles
    initial
    begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        tally_and_finish();
    end
endmodule : quant_sat_tb
`default_nettype wire
